// file: verilog/plc_config_bank.sv
// plc_config_bank: loop configuration bank with stored customer version id.
// assumes the serial control port has already turned frames into
// single-cycle byte read and write strobes on clk.
`default_nettype none

// Functional notes
// - a 16-bit customer version id sits in two bytes at 0x005 (low) and 0x006 (high), reset 0.
// - the version id is storage only and steers nothing else in the device.
// - loop control bits 6:4 set pump current from 0.6 mA (000) to 4.8 mA (111, reset).
// - loop control bits 3:2 pick pump mode: tristate, source, sink, normal (reset).
// - loop control bits 1:0 pick loop mode: normal, async down (reset), unused, sync down.
// - a 14-bit reference divider lives at 0x011 (reset 0x01) and 0x012 bits 5:0 (reset 0).
module plc_config_bank
  import plc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sysRst,
  input  wire logic [ADDR_W-1:0]    regAddr,
  input  wire logic                 regWrEn,
  input  wire logic [DATA_W-1:0]    regWrData,
  input  wire logic                 regRdEn,
  output var  logic [DATA_W-1:0]    regRdData,
  output var  logic                 regRdValid,
  output var  logic                 regRdHit,
  output var  logic                 phaseDetectorNegative,
  output var  logic [2:0]           pumpCurrentCode,
  output var  logic [PUMP_UA_W-1:0] pumpCurrentMicroamp,
  output var  logic                 pumpTristate,
  output var  logic                 pumpForceSource,
  output var  logic                 pumpForceSink,
  output var  logic                 pumpNormal,
  output var  logic                 pllActive,
  output var  logic                 pllPowerDownAsync,
  output var  logic                 pllPowerDownSync,
  output var  logic                 pllModeUnused,
  output var  logic [REF_DIV_W-1:0] referenceDivider,
  output var  logic [15:0]          customerVersionId
);

  logic [NUM_REGS-1:0][DATA_W-1:0] regQ;
  logic [NUM_REGS-1:0]             regSel;
  logic [DATA_W-1:0]               rdMux;
  logic                            rdMuxHit;

  logic [DATA_W-1:0]               rdData_q;
  logic                            rdValid_q;
  logic                            rdHit_q;

  logic                            pdNeg_q;
  logic [2:0]                      pumpCode_q;
  logic [PUMP_UA_W-1:0]            pumpUa_q;
  logic [PUMP_UA_W-1:0]            pumpUa_d;
  logic [1:0]                      pumpMode_q;
  logic [1:0]                      pllMode_q;
  logic [REF_DIV_W-1:0]            refDiv_q;
  logic [15:0]                     versionId_q;

  logic [DATA_W-1:0]               loopCtl;

  // high divider byte masked
  // exact ten-bit match, so upper address bits never alias a register
  genvar g;
  generate
    for (g = 0; g < NUM_REGS; g++) begin : gen_regs
      assign regSel[g] = (regAddr == REG_OFFSET[g]);
      plc_byte_reg #(
        .RESET_VALUE (REG_RESET[g]),
        .WRITE_MASK  (REG_MASK[g])
      ) u_reg (
        .clk    (clk),
        .sysRst (sysRst),
        .wrEn   (regWrEn && regSel[g]),
        .wrData (regWrData),
        .regQ   (regQ[g])
      );
    end
  endgenerate

  // all decoded outputs lag a write by two edges and switch together
  assign loopCtl = regQ[IDX_LOOP_CONTROL];

  // read mux; unmapped addresses answer zero
  always_comb begin
    rdMux = '0;
    rdMuxHit = 1'b0;
    for (int i = 0; i < NUM_REGS; i++) begin
      if (regSel[i]) begin
        rdMux = regQ[i];
        rdMuxHit = 1'b1;
      end
    end
  end

  // read data registered, valid one cycle after the strobe
  // data and hit stand until the next read; valid is a one-cycle pulse
  always_ff @(posedge clk) begin
    if (sysRst) begin
      rdData_q  <= 8'h00;
      rdValid_q <= 1'b0;
      rdHit_q   <= 1'b0;
    end else begin
      rdValid_q <= regRdEn;
      if (regRdEn) begin
        rdData_q <= rdMux;
        rdHit_q  <= rdMuxHit;
      end
    end
  end

  // polarity bit decode
  // passed on as written: keeping it positive on-chip is left to software
  always_ff @(posedge clk) begin
    if (sysRst) begin
      pdNeg_q <= RST_LOOP_CONTROL[POS_PD_POLARITY];
    end else begin
      pdNeg_q <= loopCtl[POS_PD_POLARITY];
    end
  end

  // pump current scale
  // reported as microamps for the pump bias trim, in equal 0.6 mA steps
  // the 4800 uA top code still fits the 13-bit field
  assign pumpUa_d = (PUMP_UA_W'(loopCtl[POS_PUMP_CUR_HI:POS_PUMP_CUR_LO]) + 13'h001)
                    * PUMP_STEP_UA;

  always_ff @(posedge clk) begin
    if (sysRst) begin
      pumpCode_q <= RST_LOOP_CONTROL[POS_PUMP_CUR_HI:POS_PUMP_CUR_LO];
      pumpUa_q   <= (PUMP_UA_W'(RST_LOOP_CONTROL[POS_PUMP_CUR_HI:POS_PUMP_CUR_LO])
                     + 13'h001) * PUMP_STEP_UA;
    end else begin
      pumpCode_q <= loopCtl[POS_PUMP_CUR_HI:POS_PUMP_CUR_LO];
      pumpUa_q   <= pumpUa_d;
    end
  end

  always_ff @(posedge clk) begin
    if (sysRst) begin
      pumpMode_q <= RST_LOOP_CONTROL[POS_PUMP_MODE_HI:POS_PUMP_MODE_LO];
    end else begin
      pumpMode_q <= loopCtl[POS_PUMP_MODE_HI:POS_PUMP_MODE_LO];
    end
  end

  always_ff @(posedge clk) begin
    if (sysRst) begin
      pllMode_q <= RST_LOOP_CONTROL[POS_PLL_MODE_HI:POS_PLL_MODE_LO];
    end else begin
      pllMode_q <= loopCtl[POS_PLL_MODE_HI:POS_PLL_MODE_LO];
    end
  end

  // divider assembly
  // no shadowing: a split two-byte update shows a mixed value for a while
  always_ff @(posedge clk) begin
    if (sysRst) begin
      refDiv_q <= {RST_REF_DIV_HIGH[REF_DIV_HIGH_W-1:0], RST_REF_DIV_LOW};
    end else begin
      refDiv_q <= {regQ[IDX_REF_DIV_HIGH][REF_DIV_HIGH_W-1:0], regQ[IDX_REF_DIV_LOW]};
    end
  end

  // storage only view
  // exported for the nonvolatile store; nothing in here reads it
  always_ff @(posedge clk) begin
    if (sysRst) begin
      versionId_q <= {RST_VERSION_ID_HIGH, RST_VERSION_ID_LOW};
    end else begin
      versionId_q <= {regQ[IDX_VERSION_ID_HIGH], regQ[IDX_VERSION_ID_LOW]};
    end
  end

  // one-hot pump mode strobes
  always_comb begin
    pumpTristate    = 1'b0;
    pumpForceSource = 1'b0;
    pumpForceSink   = 1'b0;
    pumpNormal      = 1'b0;
    case (pumpMode_q)
      PUMP_TRISTATE: pumpTristate    = 1'b1;
      PUMP_SOURCE:   pumpForceSource = 1'b1;
      PUMP_SINK:     pumpForceSink   = 1'b1;
      PUMP_NORMAL:   pumpNormal      = 1'b1;
      default:       pumpTristate    = 1'b1;
    endcase
  end

  // loop mode strobes
  // the unused code keeps the loop off: safest for the pump and oscillator
  always_comb begin
    pllActive         = 1'b0;
    pllPowerDownAsync = 1'b0;
    pllPowerDownSync  = 1'b0;
    pllModeUnused     = 1'b0;
    case (pllMode_q)
      PLL_NORMAL:   pllActive         = 1'b1;
      PLL_PD_ASYNC: pllPowerDownAsync = 1'b1;
      PLL_UNUSED:   pllModeUnused     = 1'b1;
      PLL_PD_SYNC:  pllPowerDownSync  = 1'b1;
      default:      pllModeUnused     = 1'b1;
    endcase
  end

  assign regRdData             = rdData_q;
  assign regRdValid            = rdValid_q;
  assign regRdHit              = rdHit_q;
  assign phaseDetectorNegative = pdNeg_q;
  assign pumpCurrentCode       = pumpCode_q;
  assign pumpCurrentMicroamp   = pumpUa_q;
  assign referenceDivider      = refDiv_q;
  assign customerVersionId     = versionId_q;

endmodule : plc_config_bank

`default_nettype wire

// file: verilog/plc_pkg.sv
// plc_pkg: register map, field layout, reset values and codes of the
// loop configuration bank.
// assumes byte-wide registers reached by the serial control port's
// internal address/data strobes.
`default_nettype none

package plc_pkg;

  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int NUM_REGS = 5;

  // register offsets
  localparam logic [ADDR_W-1:0] OFS_VERSION_ID_LOW  = 10'h005;
  localparam logic [ADDR_W-1:0] OFS_VERSION_ID_HIGH = 10'h006;
  localparam logic [ADDR_W-1:0] OFS_LOOP_CONTROL    = 10'h010;
  localparam logic [ADDR_W-1:0] OFS_REF_DIV_LOW     = 10'h011;
  localparam logic [ADDR_W-1:0] OFS_REF_DIV_HIGH    = 10'h012;

  // register slot indices within the bank
  localparam int IDX_VERSION_ID_LOW  = 0;
  localparam int IDX_VERSION_ID_HIGH = 1;
  localparam int IDX_LOOP_CONTROL    = 2;
  localparam int IDX_REF_DIV_LOW     = 3;
  localparam int IDX_REF_DIV_HIGH    = 4;

  // reset values
  localparam logic [DATA_W-1:0] RST_VERSION_ID_LOW  = 8'h00;
  localparam logic [DATA_W-1:0] RST_VERSION_ID_HIGH = 8'h00;
  localparam logic [DATA_W-1:0] RST_LOOP_CONTROL    = 8'h7d;
  localparam logic [DATA_W-1:0] RST_REF_DIV_LOW     = 8'h01;
  localparam logic [DATA_W-1:0] RST_REF_DIV_HIGH    = 8'h00;

  // writable bits per register
  localparam logic [DATA_W-1:0] MASK_FULL         = 8'hff;
  localparam logic [DATA_W-1:0] MASK_REF_DIV_HIGH = 8'h3f;

  // tables indexed by slot
  localparam logic [NUM_REGS-1:0][ADDR_W-1:0] REG_OFFSET = {
    OFS_REF_DIV_HIGH, OFS_REF_DIV_LOW, OFS_LOOP_CONTROL,
    OFS_VERSION_ID_HIGH, OFS_VERSION_ID_LOW};
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_RESET = {
    RST_REF_DIV_HIGH, RST_REF_DIV_LOW, RST_LOOP_CONTROL,
    RST_VERSION_ID_HIGH, RST_VERSION_ID_LOW};
  localparam logic [NUM_REGS-1:0][DATA_W-1:0] REG_MASK = {
    MASK_REF_DIV_HIGH, MASK_FULL, MASK_FULL, MASK_FULL, MASK_FULL};

  // loop control field positions
  localparam int POS_PD_POLARITY = 7;
  localparam int POS_PUMP_CUR_HI = 6;
  localparam int POS_PUMP_CUR_LO = 4;
  localparam int POS_PUMP_MODE_HI = 3;
  localparam int POS_PUMP_MODE_LO = 2;
  localparam int POS_PLL_MODE_HI = 1;
  localparam int POS_PLL_MODE_LO = 0;
  localparam int REF_DIV_W = 14;
  localparam int REF_DIV_HIGH_W = 6;

  // charge pump mode codes
  localparam logic [1:0] PUMP_TRISTATE = 2'h0;
  localparam logic [1:0] PUMP_SOURCE   = 2'h1;
  localparam logic [1:0] PUMP_SINK     = 2'h2;
  localparam logic [1:0] PUMP_NORMAL   = 2'h3;

  // loop operating mode codes
  localparam logic [1:0] PLL_NORMAL    = 2'h0;
  localparam logic [1:0] PLL_PD_ASYNC  = 2'h1;
  localparam logic [1:0] PLL_UNUSED    = 2'h2;
  localparam logic [1:0] PLL_PD_SYNC   = 2'h3;

  // pump current step in microamps; code n gives (n+1) steps
  localparam int PUMP_UA_W = 13;
  localparam logic [PUMP_UA_W-1:0] PUMP_STEP_UA = 13'h258;

endpackage : plc_pkg

`default_nettype wire

// file: verilog/plc_byte_reg.sv
// plc_byte_reg: one byte-wide configuration register with per-bit write mask.
// assumes a single-cycle write strobe on the system clock.
`default_nettype none

module plc_byte_reg
  import plc_pkg::*;
#(
  parameter logic [DATA_W-1:0] RESET_VALUE = 8'h00,
  parameter logic [DATA_W-1:0] WRITE_MASK  = 8'hff
) (
  input  wire logic              clk,
  input  wire logic              sysRst,
  input  wire logic              wrEn,
  input  wire logic [DATA_W-1:0] wrData,
  output var  logic [DATA_W-1:0] regQ
);

  logic [DATA_W-1:0] value_q;

  // masked bits stay at reset value, so they read back as it
  always_ff @(posedge clk) begin
    if (sysRst) begin
      value_q <= RESET_VALUE;
    end else if (wrEn) begin
      value_q <= (wrData & WRITE_MASK) | (RESET_VALUE & ~WRITE_MASK);
    end
  end

  assign regQ = value_q;

endmodule : plc_byte_reg

`default_nettype wire

// file: tb/plc_config_bank_properties.sv
// plc_config_bank_properties: port-level checks of the loop config bank.
// assumes one-cycle strobes; decoded outputs lag a write by two edges.
`default_nettype none

module plc_config_bank_properties
  import plc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 sysRst,
  input wire logic [ADDR_W-1:0]    regAddr,
  input wire logic                 regWrEn,
  input wire logic [DATA_W-1:0]    regWrData,
  input wire logic                 regRdEn,
  input wire logic [DATA_W-1:0]    regRdData,
  input wire logic                 regRdValid,
  input wire logic                 phaseDetectorNegative,
  input wire logic [2:0]           pumpCurrentCode,
  input wire logic                 pumpNormal,
  input wire logic                 pllPowerDownAsync,
  input wire logic [REF_DIV_W-1:0] referenceDivider,
  input wire logic [15:0]          customerVersionId
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sysRst);
  logic wrId, wrCtl, wrHi, wrCfg;
  assign wrId  = regWrEn && regAddr == 10'h005;
  assign wrCtl = regWrEn && regAddr == 10'h010;
  assign wrHi  = regWrEn && regAddr == 10'h012;
  assign wrCfg = wrCtl || (regWrEn && regAddr inside {10'h011, 10'h012});
  sequence s_ctlDone; wrCtl ##2 1'b1; endsequence
  property p_id; wrId |-> ##2 customerVersionId[7:0] == $past(regWrData, 2); endproperty
  // a late settle after reset is allowed, anything else needs a config write
  property p_stor; $changed(referenceDivider) || $changed(pumpCurrentCode)
    |-> $past(wrCfg, 2) || $past(sysRst) || $past(sysRst, 2); endproperty
  property p_pol; s_ctlDone |-> phaseDetectorNegative == $past(regWrData[7], 2); endproperty
  property p_cur; s_ctlDone |-> pumpCurrentCode == $past(regWrData[6:4], 2); endproperty
  property p_mode; s_ctlDone |-> pumpNormal == ($past(regWrData[3:2], 2) == 2'h3); endproperty
  property p_pll; s_ctlDone |-> pllPowerDownAsync == ($past(regWrData[1:0], 2) == 2'h1);
  endproperty
  property p_div; wrHi |-> ##2 referenceDivider[13:8] == $past(regWrData[5:0], 2); endproperty
  property p_rd9; regRdEn && regAddr == 10'h012 |=> regRdValid && regRdData[7:6] == 2'h0;
  endproperty
  a_id:   assert property (p_id)   else $error("version id low byte not stored");
  a_stor: assert property (p_stor) else $error("config output moved on its own");
  a_pol:  assert property (p_pol)  else $error("detector polarity wrong");
  a_cur:  assert property (p_cur)  else $error("pump current code wrong");
  a_mode: assert property (p_mode) else $error("pump mode decode wrong");
  a_pll:  assert property (p_pll)  else $error("loop mode decode wrong");
  a_div:  assert property (p_div)  else $error("divider high bits wrong");
  a_rd9:  assert property (p_rd9)  else $error("divider spare bits not zero");
endmodule : plc_config_bank_properties

bind plc_config_bank plc_config_bank_properties i_plc_config_bank_properties (.clk, .sysRst,
  .regAddr, .regWrEn, .regWrData, .regRdEn, .regRdData, .regRdValid, .phaseDetectorNegative,
  .pumpCurrentCode, .pumpNormal, .pllPowerDownAsync, .referenceDivider, .customerVersionId);

`default_nettype wire

// file: tb/tb_plc_config_bank.sv
// tb_plc_config_bank: self-checking bench with a byte model of the bank.
// assumes one-cycle read latency and outputs settling two edges after a write.
`default_nettype none

module tb_plc_config_bank
  import plc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic                 clk = 1'b0;
  logic                 sysRst = 1'b1;
  logic [ADDR_W-1:0]    regAddr = '0;
  logic                 regWrEn = 1'b0;
  logic [DATA_W-1:0]    regWrData = '0;
  logic                 regRdEn = 1'b0;
  logic [DATA_W-1:0]    regRdData;
  logic                 regRdValid, regRdHit, phaseDetectorNegative, pumpNormal;
  logic [2:0]           pumpCurrentCode;
  logic [PUMP_UA_W-1:0] pumpCurrentMicroamp;
  logic                 pumpTristate, pumpForceSource, pumpForceSink;
  logic                 pllActive, pllPowerDownAsync, pllPowerDownSync, pllModeUnused;
  logic [REF_DIV_W-1:0] referenceDivider;
  logic [15:0]          customerVersionId;
  logic [7:0]           m [5];
  // slot 5 aliases 0x005 in the low address byte and differs only in bit 8, so it must miss
  logic [ADDR_W-1:0]    ad [6] = '{10'h005, 10'h006, 10'h010, 10'h011, 10'h012, 10'h105};
  int                   n_fail = 0;
  int                   num_checks = 0;

  plc_config_bank i_plc_config_bank (.clk, .sysRst, .regAddr, .regWrEn, .regWrData, .regRdEn,
    .regRdData, .regRdValid, .regRdHit, .phaseDetectorNegative, .pumpCurrentCode,
    .pumpCurrentMicroamp, .pumpTristate, .pumpForceSource, .pumpForceSink, .pumpNormal,
    .pllActive, .pllPowerDownAsync, .pllPowerDownSync, .pllModeUnused, .referenceDivider,
    .customerVersionId);

  always #12.5 clk = ~clk;

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic doReset;
    sysRst = 1'b1;
    repeat (5) @(posedge clk);
    #2 sysRst = 1'b0;
    m = '{8'h00, 8'h00, 8'h7d, 8'h01, 8'h00};
  endtask : doReset

  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clk) #2;
    regAddr = ad[k];
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge clk) #2;
    regWrEn = 1'b0;
    if (k < 5) m[k] = d & ((k == 4) ? 8'h3f : 8'hff);
  endtask : wr

  task automatic rd(input int k);
    @(posedge clk) #2;
    regAddr = ad[k];
    regRdEn = 1'b1;
    @(posedge clk) #2;
    regRdEn = 1'b0;
    chk("rdValid", regRdValid, 1'b1);
    chk("rdData", regRdData, (k < 5) ? m[k] : 8'h00);
    chk("rdHit", regRdHit, k < 5);
  endtask : rd

  task automatic chkOut;
    logic [3:0] pm;
    logic [3:0] pl;
    @(posedge clk) #2;
    pm = {pumpNormal, pumpForceSink, pumpForceSource, pumpTristate};
    pl = {pllPowerDownSync, pllModeUnused, pllPowerDownAsync, pllActive};
    chk("polarity", phaseDetectorNegative, m[2][7]);
    chk("pumpCode", pumpCurrentCode, m[2][6:4]);
    chk("pumpUa", pumpCurrentMicroamp, 16'((m[2][6:4] + 1) * 600));
    chk("pumpMode", pm, 4'h1 << m[2][3:2]);
    chk("loopMode", pl, 4'h1 << m[2][1:0]);
    chk("divider", referenceDivider, {m[4][5:0], m[3]});
    chk("versionId", customerVersionId, {m[1], m[0]});
    chk("rdValidLow", regRdValid, 1'b0);
  endtask : chkOut

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    summarize();
  end

  initial begin
    int s;
    int k;
    s = $urandom(44);
    doReset();
    for (k = 0; k < 6; k++) rd(k);
    chkOut();
    // every current, pump mode and loop mode code, first with the on-chip oscillator
    for (k = 0; k < 16; k++) begin
      // negative polarity only from the external oscillator half on
      wr(2, {k[3], k[2:0], k[1:0], ~k[1:0]});
      chkOut();
    end
    // each slot once, then random ones; id writes must leave control outputs alone
    for (k = 0; k < 40; k++) begin
      s = (k < 6) ? k : $urandom_range(5);
      wr(s, 8'($urandom));
      rd(s);
      chkOut();
    end
    doReset();
    for (k = 0; k < 6; k++) rd(k);
    chkOut();
    summarize();
  end
endmodule : tb_plc_config_bank

`default_nettype wire
